// *** seq_pkg.sv ***
// Package: constants, types and register map of the setpoint program sequencer
package seq_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_PROGRAMS = 8;
  localparam int NUM_SEGMENTS = 12;
  localparam int PROGRAM_MODE_SELECT_W = 3;
  localparam int SEG_W = 4;
  localparam int VAL_W = 16;
  localparam int TRACK_W = 4;
  localparam int DUR_W = 14;
  // Duration field: minutes/hours high part times 60 plus low part, up to 99:59
  localparam logic [13:0] DUR_MAX = 14'h176F;
  localparam logic [13:0] DUR_END = 14'h3FFF;
  // Deviation band for waiting, in tenths of a degree: 2 degrees
  localparam logic [15:0] WAIT_BAND = 16'h0014;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 100000000;
  localparam int CONFIRM_S = 5;
  localparam longint CONFIRM_CYC = CONFIRM_S * CLK_HZ;
  localparam int SECS_PER_MIN = 60;
  // ----------------------------------------------------------------
  // Register map (word offsets in bytes)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SEG_ADDR = 8'h08;
  localparam logic [7:0] REG_SEG_DATA = 8'h0C;
  localparam logic [7:0] REG_SETPOINT = 8'h10;
  localparam logic [7:0] REG_KEYS = 8'h14;
  // Control register fields
  localparam int CTRL_MODE_ON = 0;
  localparam int CTRL_AUTO_RUN = 1;
  localparam int CTRL_WAIT = 2;
  localparam int CTRL_STEP = 3;
  localparam int CTRL_HOURS = 4;
  localparam int CTRL_RUN_IN = 5;
  localparam int CTRL_HOLD_IN = 6;
  localparam int CTRL_PROGRAM_MODE_SELECT_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  // Key register fields (write one to press)
  localparam int KEY_UP = 0;
  localparam int KEY_DOWN = 1;
  localparam int KEY_OK = 2;
  localparam int KEY_DISCARD = 3;
  // Segment data word fields: [15:0] target, [19:16] tracks, [33:20] duration
  localparam int SEG_TRK_LSB = 16;
  localparam int SEG_DUR_LSB = 20;

  typedef enum logic [1:0] {SEQ_STOP, SEQ_RUN, SEQ_WAIT, SEQ_HOLD} seq_state_t;

  typedef struct packed {
    logic [DUR_W-1:0] duration;
    logic [TRACK_W-1:0] tracks;
    logic [VAL_W-1:0] target;
  } segment_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
endpackage : seq_pkg

// *** seg_memory.sv ***
// Segment store: eight programs of twelve segments each
`timescale 1ns/1ns
`default_nettype none
module seg_memory #(
  parameter int PROGS = seq_pkg::NUM_PROGRAMS,
  parameter int SEGS = seq_pkg::NUM_SEGMENTS
) (
  // Clock
  input wire logic clk,
  // Write side
  input wire logic wrEn,
  input wire logic [6:0] wrIdx,
  input wire seq_pkg::segment_t wrSeg,
  // Read side
  input wire logic [6:0] rdIdx,
  output seq_pkg::segment_t rdSeg
);
  import seq_pkg::*;
  segment_t mem [PROGS*SEGS];
  // Storage keeps no reset so it maps to RAM; unwritten entries are undefined
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrIdx] <= wrSeg;
    end
  end
  assign rdSeg = mem[rdIdx];
endmodule : seg_memory
`default_nettype wire

// *** time_base.sv ***
// Timebase: one tick per segment unit (second or minute) from the clock
`timescale 1ns/1ns
`default_nettype none
module time_base #(
  parameter longint CYC_PER_SEC = seq_pkg::CLK_HZ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Control
  input wire logic run,
  input wire logic hours,
  // Tick out
  output logic tick
);
  import seq_pkg::*;
  logic [31:0] cycCnt_reg;
  logic [5:0] secCnt_reg;
  logic secTick;
  assign secTick = run && (cycCnt_reg == 32'(CYC_PER_SEC - 1));
  // Prescaler restarts when not running; a halt keeps whole units, drops the partial second
  always_ff @(posedge clk) begin
    if (srst || !run) begin
      cycCnt_reg <= '0;
    end else if (secTick) begin
      cycCnt_reg <= '0;
    end else begin
      cycCnt_reg <= cycCnt_reg + 32'h1;
    end
  end
  // Seconds to minutes divider for the hours:minutes unit
  always_ff @(posedge clk) begin
    if (srst) begin
      secCnt_reg <= '0;
    end else if (secTick) begin
      secCnt_reg <= (secCnt_reg == 6'(SECS_PER_MIN - 1)) ? 6'h0 : secCnt_reg + 6'h1;
    end
  end
  assign tick = secTick && (!hours || secCnt_reg == 6'(SECS_PER_MIN - 1));
endmodule : time_base
`default_nettype wire

// *** setpoint_program_sequencer.sv ***
// Setpoint program sequencer: state machine, setpoint generator and registers
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Eight stored programs of up to twelve segments; one selected program runs.
// - In program mode the active setpoint comes only from the program.
// - Segments hold duration, target, tracks; an end duration terminates the program, except in segment 1 where it runs as 99:59.
// - Stopped: controller and actuator outputs off, relative limit errors suppressed.
// - Stopped: momentary setpoint follows the measured actual value.
// - A start after stop restarts the program from its beginning.
// - Running: outputs active, limit errors enabled, segment number reported.
// - Each start begins at segment 1 from the actual value.
// - After reset, auto-run choice starts the program; default is stop. Code checks auto-run only before any control write, so it never starts.
// - Run input level starts when asserted, stops when released.
// - With waiting on, advance only when deviation is within 2 degrees.
// - Halted: setpoint and segment timer frozen, segment number shown.
// - Hold input halts the running program.
// - Segment track pattern drives track outputs for the whole segment.
// - Run and halt status outputs asserted exactly in those states.
// - Setpoint display shows momentary setpoint running, dashes after end.
// - Status display shows state and segment number.
// - Without binary inputs, up and down keys select the state.
// - Keyed change applies only if confirmed within 5 seconds; discard drops it.
// - Durations 0:00 to 99:59 in minutes:seconds or hours:minutes.
// - Program mode blocks manual and self-tuned parameter entry.
module setpoint_program_sequencer #(
  parameter longint CONFIRM_CYCLES = seq_pkg::CONFIRM_CYC,
  parameter longint CYC_PER_SEC = seq_pkg::CLK_HZ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Binary inputs and process value
  input wire logic runInput,
  input wire logic holdInput,
  input wire logic signed [15:0] actualValue,
  // Controller side
  output logic signed [15:0] activeSetpoint,
  output logic controlEnable,
  output logic limitErrEnable,
  output logic paramEntryBlock,
  // Switching outputs
  output logic [3:0] trackOut,
  output logic runOut,
  output logic holdOut,
  // Display
  output seq_pkg::seq_state_t statusState,
  output logic [3:0] statusSegment,
  output logic setpointDashes
);
  import seq_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic [6:0] segAddr_reg;
  logic [VAL_W-1:0] segLow_reg;
  seq_state_t state_reg, state_next;
  logic [SEG_W-1:0] seg_reg;
  logic [DUR_W-1:0] elapsed_reg;
  logic signed [15:0] startVal_reg;
  logic signed [15:0] setpoint_reg;
  logic ended_reg;
  logic bootDone_reg;
  logic pendValid_reg;
  seq_state_t pend_reg;
  logic [31:0] confirmCnt_reg;
  logic runInPrev_reg;

  logic modeOn, autoRun, waitOn, stepMode, hoursUnit, runInUse, holdInUse;
  logic [PROGRAM_MODE_SELECT_W-1:0] progSel;
  assign modeOn = ctrl_reg[CTRL_MODE_ON];
  assign autoRun = ctrl_reg[CTRL_AUTO_RUN];
  assign waitOn = ctrl_reg[CTRL_WAIT];
  assign stepMode = ctrl_reg[CTRL_STEP];
  assign hoursUnit = ctrl_reg[CTRL_HOURS];
  assign runInUse = ctrl_reg[CTRL_RUN_IN];
  assign holdInUse = ctrl_reg[CTRL_HOLD_IN];
  assign progSel = ctrl_reg[CTRL_PROGRAM_MODE_SELECT_LSB +: PROGRAM_MODE_SELECT_W];

  // ----------------------------------------------------------------
  // Segment store and timebase
  // ----------------------------------------------------------------
  logic segWrEn;
  segment_t wrSeg, curSeg;
  logic [6:0] rdIdx;
  logic tick;
  logic timing;
  // Upper half of a segment arrives by a second write at SEG_DATA+4
  assign segWrEn = regWr && regAddr == REG_SEG_DATA + 8'h04;
  assign wrSeg = {regWdata[DUR_W-1:0], regWdata[SEG_TRK_LSB +: TRACK_W], segLow_reg};
  assign rdIdx = 7'(progSel * NUM_SEGMENTS) + 7'(seg_reg);

  seg_memory #(.PROGS(NUM_PROGRAMS), .SEGS(NUM_SEGMENTS)) u_mem (
    .clk(clk),
    .wrEn(segWrEn),
    .wrIdx(segAddr_reg),
    .wrSeg(wrSeg),
    .rdIdx(rdIdx),
    .rdSeg(curSeg)
  );

  assign timing = modeOn && state_reg == SEQ_RUN;
  time_base #(.CYC_PER_SEC(CYC_PER_SEC)) u_tb (
    .clk(clk),
    .srst(srst),
    .run(timing),
    .hours(hoursUnit),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // Segment progress
  // ----------------------------------------------------------------
  logic [DUR_W-1:0] dur;
  logic isEnd, timeUp, lastSeg, nearTarget;
  logic signed [16:0] dev;
  // Durations above 99:59 are clamped; the end code only counts after segment 1
  assign isEnd = (curSeg.duration == DUR_END) && seg_reg != '0;
  assign dur = (curSeg.duration > DUR_MAX) ? DUR_MAX : curSeg.duration;
  assign timeUp = elapsed_reg >= dur;
  assign lastSeg = seg_reg == SEG_W'(NUM_SEGMENTS - 1);
  assign dev = 17'(actualValue) - 17'($signed(curSeg.target));
  // Band limits are signed so a negative deviation compares as negative
  assign nearTarget = (dev <= $signed(17'(WAIT_BAND))) && (dev >= -$signed(17'(WAIT_BAND)));

  // ----------------------------------------------------------------
  // Command sources: binary inputs or confirmed keys
  // ----------------------------------------------------------------
  logic keyWr, keyUp, keyDown, keyOk, keyDiscard, keyApply, confirmExpired;
  assign keyWr = regWr && regAddr == REG_KEYS && !runInUse && !holdInUse;
  assign keyUp = keyWr && regWdata[KEY_UP];
  assign keyDown = keyWr && regWdata[KEY_DOWN];
  assign keyOk = keyWr && regWdata[KEY_OK];
  assign keyDiscard = keyWr && regWdata[KEY_DISCARD];
  assign keyApply = keyOk && pendValid_reg;
  assign confirmExpired = confirmCnt_reg >= 32'(CONFIRM_CYCLES - 1);

  // Pending keyed state: scroll cycles stop, run, hold
  always_ff @(posedge clk) begin
    if (srst) begin
      pendValid_reg <= 1'b0;
      pend_reg <= SEQ_STOP;
      confirmCnt_reg <= '0;
    end else if (keyUp || keyDown) begin
      pendValid_reg <= 1'b1;
      confirmCnt_reg <= '0;
      case (pendValid_reg ? pend_reg : state_reg)
        SEQ_STOP: pend_reg <= keyUp ? SEQ_RUN : SEQ_HOLD;
        SEQ_HOLD: pend_reg <= keyUp ? SEQ_STOP : SEQ_RUN;
        default: pend_reg <= keyUp ? SEQ_HOLD : SEQ_STOP;
      endcase
    end else if (keyApply || keyDiscard || (pendValid_reg && confirmExpired)) begin
      pendValid_reg <= 1'b0;
      confirmCnt_reg <= '0;
    end else if (pendValid_reg) begin
      confirmCnt_reg <= confirmCnt_reg + 32'h1;
    end
  end

  // Edge of the run input; a start is the rising edge, a stop is the low level
  always_ff @(posedge clk) begin
    if (srst) begin
      runInPrev_reg <= 1'b0;
    end else begin
      runInPrev_reg <= runInput;
    end
  end

  logic cmdStart, cmdStop, cmdHold, cmdResume;
  always_comb begin
    cmdStart = 1'b0;
    cmdStop = 1'b0;
    cmdHold = 1'b0;
    cmdResume = 1'b0;
    if (runInUse) begin
      cmdStart = runInput && !runInPrev_reg;
      cmdStop = !runInput;
    end else if (keyApply) begin
      cmdStart = pend_reg == SEQ_RUN && state_reg == SEQ_STOP;
      cmdResume = pend_reg == SEQ_RUN && state_reg == SEQ_HOLD;
      cmdStop = pend_reg == SEQ_STOP;
      cmdHold = pend_reg == SEQ_HOLD;
    end
    if (holdInUse) begin
      cmdHold = holdInput;
      cmdResume = !holdInput;
    end
    if (!bootDone_reg && autoRun) begin
      cmdStart = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Sequence state machine
  // ----------------------------------------------------------------
  logic advance, finish;
  assign advance = (state_reg == SEQ_RUN || state_reg == SEQ_WAIT) && timeUp
    && (!waitOn || nearTarget);
  assign finish = advance && (lastSeg || isEnd);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SEQ_STOP: begin
        if (cmdStart) state_next = SEQ_RUN;
      end
      SEQ_RUN, SEQ_WAIT: begin
        if (cmdStop || finish || isEnd) state_next = SEQ_STOP;
        else if (cmdHold) state_next = SEQ_HOLD;
        else if (timeUp && waitOn && !nearTarget) state_next = SEQ_WAIT;
        else state_next = SEQ_RUN;
      end
      SEQ_HOLD: begin
        if (cmdStop) state_next = SEQ_STOP;
        else if (cmdResume) state_next = SEQ_RUN;
      end
      default: state_next = SEQ_STOP;
    endcase
    if (!modeOn) state_next = SEQ_STOP;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= SEQ_STOP;
      bootDone_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bootDone_reg <= 1'b1;
    end
  end

  // Segment index and timer; every start resets to segment 1
  always_ff @(posedge clk) begin
    if (srst) begin
      seg_reg <= '0;
      elapsed_reg <= '0;
      ended_reg <= 1'b0;
    end else if (state_reg == SEQ_STOP) begin
      if (state_next == SEQ_RUN) begin
        seg_reg <= '0;
        elapsed_reg <= '0;
        ended_reg <= 1'b0;
      end
    end else if (state_next == SEQ_STOP) begin
      ended_reg <= 1'b1;
    end else if (advance) begin
      seg_reg <= seg_reg + SEG_W'(1);
      elapsed_reg <= '0;
    end else if (tick && !timeUp) begin
      elapsed_reg <= elapsed_reg + DUR_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Setpoint generator
  // ----------------------------------------------------------------
  logic signed [15:0] rampVal;
  logic signed [31:0] span;
  always_comb begin
    span = 32'(signed'(curSeg.target) - startVal_reg) * $signed({18'h0, elapsed_reg});
    if (stepMode || dur == '0 || timeUp) begin
      rampVal = curSeg.target;
    end else begin
      rampVal = 16'(startVal_reg + 16'(span / $signed({18'h0, dur})));
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      startVal_reg <= '0;
      setpoint_reg <= '0;
    end else begin
      case (state_reg)
        SEQ_STOP: begin
          setpoint_reg <= actualValue;
          startVal_reg <= actualValue;
        end
        SEQ_RUN, SEQ_WAIT: begin
          setpoint_reg <= rampVal;
          if (advance) startVal_reg <= curSeg.target;
        end
        SEQ_HOLD: setpoint_reg <= setpoint_reg;
        default: setpoint_reg <= actualValue;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      activeSetpoint <= '0;
      controlEnable <= 1'b0;
      limitErrEnable <= 1'b0;
      paramEntryBlock <= 1'b0;
      trackOut <= '0;
      runOut <= 1'b0;
      holdOut <= 1'b0;
      statusState <= SEQ_STOP;
      statusSegment <= '0;
      setpointDashes <= 1'b0;
    end else begin
      activeSetpoint <= setpoint_reg;
      controlEnable <= state_reg != SEQ_STOP;
      limitErrEnable <= state_reg != SEQ_STOP;
      // Stays blocked until the forced stop has settled after mode off
      paramEntryBlock <= modeOn || state_reg != SEQ_STOP;
      trackOut <= (state_reg != SEQ_STOP) ? curSeg.tracks : '0;
      runOut <= state_reg == SEQ_RUN || state_reg == SEQ_WAIT;
      holdOut <= state_reg == SEQ_HOLD;
      statusState <= state_reg;
      statusSegment <= seg_reg + SEG_W'(1);
      setpointDashes <= modeOn && state_reg == SEQ_STOP && ended_reg;
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_reg <= CTRL_RESET;
      segAddr_reg <= '0;
      segLow_reg <= '0;
    end else if (regWr) begin
      case (regAddr)
        REG_CTRL: ctrl_reg <= regWdata;
        REG_SEG_ADDR: segAddr_reg <= regWdata[6:0];
        REG_SEG_DATA: segLow_reg <= regWdata[VAL_W-1:0];
        default: ;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk) begin
    if (srst || !regRd) begin
      regRdata <= '0;
    end else begin
      case (regAddr)
        REG_CTRL: regRdata <= ctrl_reg;
        REG_STATUS: regRdata <= {24'h0, ended_reg, pendValid_reg, seg_reg, state_reg};
        REG_SEG_ADDR: regRdata <= {25'h0, segAddr_reg};
        REG_SETPOINT: regRdata <= {16'h0, setpoint_reg};
        REG_KEYS: regRdata <= {29'h0, pend_reg, pendValid_reg};
        default: regRdata <= '0;
      endcase
    end
  end
endmodule : setpoint_program_sequencer
`default_nettype wire

// *** seq_assertions.sv ***
// Checker: port relations of the setpoint program sequencer
`timescale 1ns/1ns
`default_nettype none
module seq_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Observed ports
  input wire logic signed [15:0] actualValue,
  input wire logic signed [15:0] activeSetpoint,
  input wire logic controlEnable,
  input wire logic limitErrEnable,
  input wire logic paramEntryBlock,
  input wire logic [3:0] trackOut,
  input wire logic runOut,
  input wire logic holdOut,
  input wire seq_pkg::seq_state_t statusState,
  input wire logic [3:0] statusSegment,
  input wire logic setpointDashes
);
  import seq_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ----
  // Named steps
  // ----
  // Four quiet cycles let the registered setpoint catch up with the input
  sequence stopSteady;
    (statusState == SEQ_STOP && $stable(actualValue)) [*4];
  endsequence
  sequence leaveStop;
    $past(statusState) == SEQ_STOP && statusState != SEQ_STOP;
  endsequence
  sequence holdTwice;
    $past(statusState) == SEQ_HOLD && statusState == SEQ_HOLD;
  endsequence
  sequence segChange;
    $past(statusState) != SEQ_STOP && statusState != SEQ_STOP
      && statusSegment != $past(statusSegment);
  endsequence
  // ----
  // Assertions
  // ----
  a_stop_outputs_off: assert property (statusState == SEQ_STOP |->
    !controlEnable && !limitErrEnable && trackOut == 4'h0) else $error("outputs on in stop");
  a_run_outputs_on: assert property (statusState != SEQ_STOP |->
    controlEnable && limitErrEnable && paramEntryBlock) else $error("outputs off in run");
  a_run_flag_exact: assert property (runOut == (statusState inside {SEQ_RUN, SEQ_WAIT}))
    else $error("run flag wrong");
  a_hold_flag_exact: assert property (holdOut == (statusState == SEQ_HOLD))
    else $error("hold flag wrong");
  a_stop_follows_actual: assert property (stopSteady |-> activeSetpoint == actualValue)
    else $error("setpoint not actual in stop");
  a_hold_freezes: assert property (holdTwice |-> $stable(activeSetpoint)
    && $stable(statusSegment)) else $error("hold not frozen");
  a_start_first_seg: assert property (leaveStop |-> statusSegment == 4'h1)
    else $error("start not at segment one");
  a_seg_in_range: assert property (statusState != SEQ_STOP |->
    statusSegment inside {[4'h1:4'hC]}) else $error("segment out of range");
  a_seg_steps_one: assert property (segChange |->
    statusSegment == $past(statusSegment) + 4'h1) else $error("segment skipped");
  a_dashes_in_stop: assert property (setpointDashes |-> statusState == SEQ_STOP)
    else $error("dashes while active");
endmodule : seq_assertions
bind setpoint_program_sequencer seq_assertions chk (.clk, .srst, .actualValue,
  .activeSetpoint, .controlEnable, .limitErrEnable, .paramEntryBlock, .trackOut,
  .runOut, .holdOut, .statusState, .statusSegment, .setpointDashes);
`default_nettype wire

// *** seq_partner.sv ***
// Partner: binary input contacts and a slow plant behind the controller
`timescale 1ns/1ns
`default_nettype none
module seq_partner (
  // Clock
  input wire logic clk,
  // Bench commands
  input wire logic runCmd,
  input wire logic holdCmd,
  input wire logic loadStart,
  input wire logic signed [15:0] startValue,
  // Controller side
  input wire logic signed [15:0] activeSetpoint,
  input wire logic controlEnable,
  // Contacts and process value
  output logic runInput = 1'b0,
  output logic holdInput = 1'b0,
  output logic signed [15:0] actualValue = 16'sh0000
);
  // Contacts are levels, moved only just after an edge
  always @(posedge clk) begin
    runInput <= runCmd;
    holdInput <= holdCmd;
  end
  // Plant creeps one tenth a cycle, so large steps really lag the setpoint
  always @(posedge clk) begin
    if (loadStart) begin
      actualValue <= startValue;
    end else if (controlEnable && actualValue < activeSetpoint) begin
      actualValue <= actualValue + 16'sh0001;
    end else if (controlEnable && actualValue > activeSetpoint) begin
      actualValue <= actualValue - 16'sh0001;
    end
  end
endmodule : seq_partner
`default_nettype wire

// *** tb.sv ***
// Testbench: sequencer with partner, checker and read scoreboard
`timescale 1ns/1ns
`default_nettype none
module tb;
  import seq_pkg::*;
  // ----
  // Signals
  // ----
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic runCmd = 1'b0;
  logic holdCmd = 1'b0;
  logic loadStart = 1'b1;
  logic rdSeen = 1'b0;
  logic [31:0] regRdata;
  logic runInput, holdInput, controlEnable, limitErrEnable, paramEntryBlock;
  logic runOut, holdOut, setpointDashes;
  logic [3:0] trackOut, statusSegment;
  logic signed [15:0] actualValue, activeSetpoint, dev;
  logic signed [15:0] tgt [3];
  seq_state_t statusState;
  logic [31:0] expQ [$];
  int n_errors = 0;
  int n_compared = 0;
  int n;
  always #5 clk = ~clk;
  // Short counts keep key timeouts and segments within a few hundred cycles
  setpoint_program_sequencer #(.CONFIRM_CYCLES(50), .CYC_PER_SEC(4)) dut (.clk, .srst,
    .regAddr, .regWdata, .regWr, .regRd, .regRdata, .runInput, .holdInput, .actualValue,
    .activeSetpoint, .controlEnable, .limitErrEnable, .paramEntryBlock, .trackOut, .runOut,
    .holdOut, .statusState, .statusSegment, .setpointDashes);
  seq_partner partner (.clk, .runCmd, .holdCmd, .loadStart, .startValue(16'sh00FA),
    .activeSetpoint, .controlEnable, .runInput, .holdInput, .actualValue);
  // ----
  // Tasks
  // ----
  task automatic tally_and_finish();
    if (n_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  // A idle cycle after each strobe keeps every signal to one assignment a step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
  endtask : rd
  task automatic wseg(input int i, input logic [15:0] t, input logic [13:0] d, input logic [3:0] k);
    wr(REG_SEG_ADDR, 32'(i));
    wr(REG_SEG_DATA, {16'h0000, t});
    wr(REG_SETPOINT, {12'h000, k, 2'b00, d});
  endtask : wseg
  // Bounded wait for a displayed state and segment (0 means any segment)
  task automatic await(input seq_state_t s, input logic [3:0] sg, output int c);
    for (c = 0; c < 1000; c++) begin
      @(posedge clk);
      if (statusState === s && (sg === 4'h0 || statusSegment === sg)) return;
    end
    chk(32'h0, 32'h1, "wait ran out");
    tally_and_finish();
  endtask : await
  // Read data stand only in the cycle after the strobe; compare with oldest note
  always @(posedge clk) begin
    if (rdSeen) begin
      chk(regRdata, expQ.pop_front(), "read data");
    end
    rdSeen <= regRd;
  end
  // ----
  // Main sequence
  // ----
  initial begin
    void'($urandom(32'h4ca23c6f));
    tgt[0] = 16'sh012C + 16'($urandom_range(200));
    tgt[1] = 16'sh0064 + 16'($urandom_range(200));
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    loadStart <= 1'b0;
    @(posedge clk);
    rd(REG_CTRL, CTRL_RESET);
    wr(8'h3C, 32'hFFFFFFFF);
    rd(8'h3C, 32'h0);
    chk(statusState, SEQ_STOP, "state after reset");
    wseg(24, tgt[0], 14'h0002, 4'h5);
    wseg(25, tgt[1], 14'h0001, 4'hA);
    wseg(26, 16'h0000, DUR_END, 4'hF);
    wr(REG_CTRL, 32'h00000269);
    rd(REG_CTRL, 32'h00000269);
    runCmd <= 1'b1;
    await(SEQ_RUN, 4'h1, n);
    repeat (3) @(posedge clk);
    chk(trackOut, 4'h5, "tracks one");
    chk(activeSetpoint, tgt[0], "step target");
    chk(paramEntryBlock, 1'b1, "entry blocked");
    await(SEQ_RUN, 4'h2, n);
    chk(32'(n >= 4 && n <= 6), 32'h1, "two second segment");
    repeat (2) @(posedge clk);
    chk(trackOut, 4'hA, "tracks two");
    await(SEQ_STOP, 4'h0, n);
    @(posedge clk);
    chk(setpointDashes, 1'b1, "dashes after end");
    runCmd <= 1'b0;
    repeat (2) @(posedge clk);
    runCmd <= 1'b1;
    await(SEQ_RUN, 4'h1, n);
    holdCmd <= 1'b1;
    await(SEQ_HOLD, 4'h1, n);
    repeat (40) @(posedge clk);
    chk(statusSegment, 4'h1, "held segment");
    holdCmd <= 1'b0;
    await(SEQ_RUN, 4'h2, n);
    runCmd <= 1'b0;
    await(SEQ_STOP, 4'h0, n);
    runCmd <= 1'b1;
    await(SEQ_RUN, 4'h1, n);
    runCmd <= 1'b0;
    await(SEQ_STOP, 4'h0, n);
    // Far target makes the slow plant lag, forcing a wait at segment end
    tgt[2] = actualValue + 16'sh0258;
    wseg(24, tgt[2], 14'h0001, 4'h3);
    wr(REG_CTRL, 32'h0000026D);
    runCmd <= 1'b1;
    await(SEQ_WAIT, 4'h1, n);
    dev = tgt[2] - actualValue;
    chk(32'(dev > 16'sh0014), 32'h1, "wait entered early");
    chk(controlEnable, 1'b1, "active while waiting");
    await(SEQ_RUN, 4'h2, n);
    dev = tgt[2] - actualValue;
    chk(32'(dev <= 16'sh0014), 32'h1, "left wait outside band");
    runCmd <= 1'b0;
    await(SEQ_STOP, 4'h0, n);
    // Keypad in ramp mode: discard, late confirm, then a confirmed start
    wr(REG_CTRL, 32'h00000201);
    dev = actualValue;
    wr(REG_KEYS, 32'h00000001);
    wr(REG_KEYS, 32'h00000008);
    wr(REG_KEYS, 32'h00000004);
    @(posedge clk);
    chk(statusState, SEQ_STOP, "discarded key");
    wr(REG_KEYS, 32'h00000001);
    repeat (60) @(posedge clk);
    wr(REG_KEYS, 32'h00000004);
    @(posedge clk);
    chk(statusState, SEQ_STOP, "late confirm");
    wr(REG_KEYS, 32'h00000001);
    wr(REG_KEYS, 32'h00000004);
    await(SEQ_RUN, 4'h1, n);
    @(posedge clk);
    chk(activeSetpoint, dev, "ramp starts at actual");
    wr(REG_CTRL, 32'h00000000);
    await(SEQ_STOP, 4'h0, n);
    @(posedge clk);
    chk(paramEntryBlock, 1'b0, "mode off");
    repeat (4) @(posedge clk);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
